// ### core/rs485_ctrl.sv
// rs485 driver direction control and 9-bit multidrop receive filter with wishbone registers
`timescale 1ns/1ps
// ============================================================================
// Overview of operation
// - outside auto mode rts follows modem control bit, or flow logic when enabled.
// - auto-direction enable bit gives the transmitter rts, overriding both others.
// - auto mode drives rts low on fifo write, high after last stop bit.
// - inversion bit flips auto-mode rts: high while pending, low when done.
// - multidrop bit selects 9-bit mode; ninth bit one marks address character.
// - in normal multidrop, a disabled receiver drops data characters.
// - address character sets parity error, enters fifo, raises line status irq.
// - enabled receiver takes all characters, flags new address characters again.
// - special detect compares addresses with second pause char, drops others.
// - matching address enables receiver, stores char with ninth bit as parity flag.
// - later non-matching address disables receiver and is dropped.
module rs485_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // transmitter side
  input  wire logic        tx_fifo_write_i,
  input  wire logic        tx_done_i,
  input  wire logic        flow_rts_n_i,
  // receiver side
  input  wire logic        rx_char_valid_i,
  input  wire logic [7:0]  rx_char_data_i,
  input  wire logic        rx_char_ninth_i,
  input  wire logic        rx_parity_err_i,
  // outputs
  output logic             rts_n_o,
  output logic             rx_push_o,
  output logic [7:0]       rx_push_data_o,
  output logic             rx_push_perr_o,
  output logic             irq_o
);

  // ==========================================================================
  // registers
  logic [7:0] modem_control_reg;
  logic [7:0] extra_features_control_reg;
  logic [7:0] enhanced_feature_reg;
  logic [7:0] line_format_reg;
  logic [7:0] interrupt_enable_reg;
  logic [7:0] second_pause_char;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] rx_hold;
  logic       rx_hold_perr;
  logic       rx_hold_full;
  logic       perr_sticky;
  logic       rx_enabled;
  logic       rts_level;
  rs485_pkg::dir_state_t dir_state;
  rs485_pkg::rx_char_t   rx_in;

  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic lane0;
  logic multidrop;
  logic special_det;
  logic is_addr;
  logic addr_match;
  logic accept;
  logic store;
  logic store_perr;
  logic auto_en_set;
  logic auto_en_clr;
  logic line_irq_evt;
  logic [7:0] line_state;
  logic [7:0] next_irq_status;

  assign rx_in = '{data: rx_char_data_i, ninth: rx_char_ninth_i};

  // ==========================================================================
  // wishbone decode
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr  = bus_req && wb_we_i;
  assign bus_rd  = bus_req && !wb_we_i;
  assign lane0   = wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      modem_control_reg          <= rs485_pkg::RESET_BYTE;
      extra_features_control_reg <= rs485_pkg::RESET_BYTE;
      enhanced_feature_reg       <= rs485_pkg::RESET_BYTE;
      line_format_reg            <= rs485_pkg::RESET_BYTE;
      interrupt_enable_reg       <= rs485_pkg::RESET_BYTE;
      second_pause_char          <= rs485_pkg::RESET_BYTE;
      irq_mask                   <= rs485_pkg::RESET_BYTE;
    end else if (bus_wr && lane0) begin
      case (wb_adr_i)
        rs485_pkg::OFF_MODEM_CONTROL:  modem_control_reg          <= wb_dat_i[7:0];
        rs485_pkg::OFF_EXTRA_FEATURES: extra_features_control_reg <= wb_dat_i[7:0];
        rs485_pkg::OFF_ENHANCED:       enhanced_feature_reg       <= wb_dat_i[7:0];
        rs485_pkg::OFF_LINE_FORMAT:    line_format_reg            <= wb_dat_i[7:0];
        rs485_pkg::OFF_INT_ENABLE:     interrupt_enable_reg       <= wb_dat_i[7:0];
        rs485_pkg::OFF_PAUSE_CHAR2:    second_pause_char          <= wb_dat_i[7:0];
        rs485_pkg::OFF_IRQ_MASK:       irq_mask                   <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    line_state = 8'h00;
    line_state[rs485_pkg::LSR_RX_READY]   = rx_hold_full;
    line_state[rs485_pkg::LSR_PARITY_ERR] = perr_sticky;
    line_state[rs485_pkg::LSR_TX_IDLE]    = (dir_state == rs485_pkg::DIR_IDLE);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_rd) begin
      case (wb_adr_i)
        rs485_pkg::OFF_MODEM_CONTROL:  wb_dat_o <= rs485_pkg::pad_byte(modem_control_reg);
        rs485_pkg::OFF_EXTRA_FEATURES: wb_dat_o <= rs485_pkg::pad_byte(extra_features_control_reg);
        rs485_pkg::OFF_ENHANCED:       wb_dat_o <= rs485_pkg::pad_byte(enhanced_feature_reg);
        rs485_pkg::OFF_LINE_FORMAT:    wb_dat_o <= rs485_pkg::pad_byte(line_format_reg);
        rs485_pkg::OFF_INT_ENABLE:     wb_dat_o <= rs485_pkg::pad_byte(interrupt_enable_reg);
        rs485_pkg::OFF_LINE_STATE:     wb_dat_o <= rs485_pkg::pad_byte(line_state);
        rs485_pkg::OFF_PAUSE_CHAR2:    wb_dat_o <= rs485_pkg::pad_byte(second_pause_char);
        rs485_pkg::OFF_RX_ENABLE:      wb_dat_o <= {31'h0000_0000, rx_enabled};
        rs485_pkg::OFF_RX_DATA:        wb_dat_o <= {23'h00_0000, rx_hold_perr, rx_hold};
        rs485_pkg::OFF_IRQ_STATUS:     wb_dat_o <= rs485_pkg::pad_byte(irq_status);
        rs485_pkg::OFF_IRQ_MASK:       wb_dat_o <= rs485_pkg::pad_byte(irq_mask);
        default:                       wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // rts direction control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_state <= rs485_pkg::DIR_IDLE;
    end else begin
      case (dir_state)
        rs485_pkg::DIR_IDLE: begin
          if (tx_fifo_write_i) begin
            dir_state <= rs485_pkg::DIR_PENDING;
          end
        end
        rs485_pkg::DIR_PENDING: begin
          // a write in the same cycle keeps the line driven
          if (tx_done_i && !tx_fifo_write_i) begin
            dir_state <= rs485_pkg::DIR_IDLE;
          end
        end
        default: dir_state <= rs485_pkg::DIR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rts_level <= 1'b1;
    end else if (extra_features_control_reg[rs485_pkg::EXTRA_FEATURES_CONTROL_REG_AUTO_DIR]) begin
      // auto mode overrides manual and flow control
      if (extra_features_control_reg[rs485_pkg::EXTRA_FEATURES_CONTROL_REG_DIR_INVERT]) begin
        rts_level <= (dir_state == rs485_pkg::DIR_PENDING);
      end else begin
        rts_level <= (dir_state != rs485_pkg::DIR_PENDING);
      end
    end else if (enhanced_feature_reg[rs485_pkg::EFR_HW_FLOW]) begin
      rts_level <= flow_rts_n_i;
    end else begin
      rts_level <= ~modem_control_reg[rs485_pkg::MCR_RTS_BIT];
    end
  end

  assign rts_n_o = rts_level;

  // ==========================================================================
  // multidrop receive filter
  assign multidrop   = extra_features_control_reg[rs485_pkg::EXTRA_FEATURES_CONTROL_REG_MULTIDROP];
  assign special_det = enhanced_feature_reg[rs485_pkg::EFR_SPECIAL_DET];
  assign is_addr     = multidrop && rx_in.ninth;
  assign addr_match  = is_addr && (rx_in.data == second_pause_char);

  always_comb begin
    accept      = 1'b0;
    store_perr  = rx_parity_err_i;
    auto_en_set = 1'b0;
    auto_en_clr = 1'b0;
    if (!multidrop) begin
      accept = 1'b1;
    end else if (!special_det) begin
      // data dropped while disabled, addresses always kept and flagged
      accept     = is_addr || rx_enabled;
      store_perr = is_addr;
    end else begin
      if (addr_match) begin
        accept      = 1'b1;
        auto_en_set = 1'b1;
        store_perr  = rx_in.ninth;
      end else if (is_addr) begin
        auto_en_clr = 1'b1;
      end else begin
        accept     = rx_enabled;
        store_perr = 1'b0;
      end
    end
  end

  assign store        = rx_char_valid_i && accept;
  assign line_irq_evt = store && store_perr;

  // match event after a software write in the same cycle wins as the later event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_enabled <= 1'b0;
    end else if (rx_char_valid_i && auto_en_set) begin
      rx_enabled <= 1'b1;
    end else if (rx_char_valid_i && auto_en_clr) begin
      rx_enabled <= 1'b0;
    end else if (bus_wr && lane0 && wb_adr_i == rs485_pkg::OFF_RX_ENABLE) begin
      rx_enabled <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_push_o      <= 1'b0;
      rx_push_data_o <= rs485_pkg::RESET_BYTE;
      rx_push_perr_o <= 1'b0;
    end else begin
      rx_push_o <= store;
      if (store) begin
        rx_push_data_o <= rx_in.data;
        rx_push_perr_o <= store_perr;
      end
    end
  end

  // holding copy of the newest stored character; deeper storage lives in the fifo
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_hold      <= rs485_pkg::RESET_BYTE;
      rx_hold_perr <= 1'b0;
      rx_hold_full <= 1'b0;
    end else if (store) begin
      rx_hold      <= rx_in.data;
      rx_hold_perr <= store_perr;
      rx_hold_full <= 1'b1;
    end else if (bus_rd && wb_adr_i == rs485_pkg::OFF_RX_DATA) begin
      rx_hold_full <= 1'b0;
    end
  end

  // parity error sticky: set wins over read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      perr_sticky <= 1'b0;
    end else if (line_irq_evt) begin
      perr_sticky <= 1'b1;
    end else if (bus_rd && wb_adr_i == rs485_pkg::OFF_LINE_STATE) begin
      perr_sticky <= 1'b0;
    end
  end

  // ==========================================================================
  // interrupts
  always_comb begin
    next_irq_status = irq_status;
    if (bus_rd && wb_adr_i == rs485_pkg::OFF_IRQ_STATUS) begin
      next_irq_status = 8'h00;
    end
    if (store && is_addr) begin
      next_irq_status[rs485_pkg::IRQ_ADDR_CHAR] = 1'b1;
    end
    if (line_irq_evt && interrupt_enable_reg[rs485_pkg::IER_LINE_STATUS]) begin
      next_irq_status[rs485_pkg::IRQ_LINE_STATUS] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= 8'h00;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  assign irq_o = |(irq_status & irq_mask);

endmodule // rs485_ctrl

// ### pkg/rs485_pkg.sv
// package: register map, field positions and types for the rs485 direction and multidrop block
package rs485_pkg;

  // ==========================================================================
  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] OFF_MODEM_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_EXTRA_FEATURES  = 8'h04;
  localparam logic [7:0] OFF_ENHANCED        = 8'h08;
  localparam logic [7:0] OFF_LINE_FORMAT     = 8'h0C;
  localparam logic [7:0] OFF_INT_ENABLE      = 8'h10;
  localparam logic [7:0] OFF_LINE_STATE      = 8'h14;
  localparam logic [7:0] OFF_PAUSE_CHAR2     = 8'h18;
  localparam logic [7:0] OFF_RX_ENABLE       = 8'h1C;
  localparam logic [7:0] OFF_RX_DATA         = 8'h20;
  localparam logic [7:0] OFF_IRQ_STATUS      = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK        = 8'h28;

  // ==========================================================================
  // field positions
  localparam int MCR_RTS_BIT      = 1;
  localparam int EXTRA_FEATURES_CONTROL_REG_MULTIDROP   = 0;
  localparam int EXTRA_FEATURES_CONTROL_REG_AUTO_DIR    = 4;
  localparam int EXTRA_FEATURES_CONTROL_REG_DIR_INVERT  = 5;
  localparam int EFR_HW_FLOW      = 6;
  localparam int EFR_SPECIAL_DET  = 5;
  localparam int IER_LINE_STATUS  = 2;
  localparam int LSR_PARITY_ERR   = 2;
  localparam int LSR_RX_READY     = 0;
  localparam int LSR_TX_IDLE      = 6;
  localparam logic [2:0] LCR_FORCE_ZERO = 3'h7;
  localparam int LCR_PARITY_LO    = 3;

  // irq status bits
  localparam int IRQ_ADDR_CHAR    = 0;
  localparam int IRQ_LINE_STATUS  = 1;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
  } rx_char_t;

  typedef enum logic [1:0] {
    DIR_IDLE    = 2'b00,
    DIR_PENDING = 2'b01
  } dir_state_t;

  function automatic logic [31:0] pad_byte(input logic [7:0] b);
    pad_byte = {24'h0000_00, b};
  endfunction

endpackage

// ### verification/rs485_ctrl_assertions.sv
// checker: bus, receive, rts and interrupt timing of rs485_ctrl
`timescale 1ns/1ps
// ==========================================================================
// checker
module rs485_ctrl_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        tx_fifo_write_i,
  input wire logic        tx_done_i,
  input wire logic        flow_rts_n_i,
  input wire logic        rx_char_valid_i,
  input wire logic [7:0]  rx_char_data_i,
  input wire logic        rts_n_o,
  input wire logic        rx_push_o,
  input wire logic [7:0]  rx_push_data_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_taken_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  write_keeps_data_a: assert property (wb_ack_o && wb_we_i |-> $stable(wb_dat_o))
    else $error("read data moved on a write");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h2C |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  push_cause_a: assert property (rx_push_o |-> $past(rx_char_valid_i) && rx_push_data_o == $past(rx_char_data_i))
    else $error("push without matching char");
  // rts may only move after a fifo write, a finished frame, a register write or flow logic
  rts_cause_a: assert property ($changed(rts_n_o) |-> $past(tx_fifo_write_i, 2) || $past(tx_done_i, 2)
    || $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(flow_rts_n_i) != $past(flow_rts_n_i, 2))
    else $error("rts moved without cause");
  irq_rise_a: assert property ($rose(irq_o) |-> $past(rx_char_valid_i) || wb_ack_o)
    else $error("irq rose without event");
  irq_fall_a: assert property ($fell(irq_o) |-> wb_ack_o)
    else $error("irq fell without access");
endmodule // rs485_ctrl_assertions

bind rs485_ctrl rs485_ctrl_assertions rs485_ctrl_assertions_inst (
  .clk_i           (clk_i),
  .rst_i           (rst_i),
  .wb_cyc_i        (wb_cyc_i),
  .wb_stb_i        (wb_stb_i),
  .wb_we_i         (wb_we_i),
  .wb_adr_i        (wb_adr_i),
  .wb_dat_o        (wb_dat_o),
  .wb_ack_o        (wb_ack_o),
  .tx_fifo_write_i (tx_fifo_write_i),
  .tx_done_i       (tx_done_i),
  .flow_rts_n_i    (flow_rts_n_i),
  .rx_char_valid_i (rx_char_valid_i),
  .rx_char_data_i  (rx_char_data_i),
  .rts_n_o         (rts_n_o),
  .rx_push_o       (rx_push_o),
  .rx_push_data_o  (rx_push_data_o),
  .irq_o           (irq_o)
);

// ### verification/rs485_line_model.sv
// line model: transmitter reports the last stop bit after a chosen delay
`timescale 1ns/1ps
// ==========================================================================
// transmit side seen through the transceiver
module rs485_line_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       fifo_write_i,
  input  wire logic [5:0] delay_i,
  output logic            done_o
);
  logic [5:0] cnt;
  // a new write restarts the frame, so done never comes early
  always_ff @(posedge clk_i) begin
    if (rst_i || fifo_write_i) begin
      cnt <= rst_i ? 6'h00 : delay_i;
    end else if (cnt != 6'h00) begin
      cnt <= cnt - 6'h01;
    end
    done_o <= !rst_i && !fifo_write_i && cnt == 6'h01;
  end
endmodule // rs485_line_model

// ### verification/test_uart_rs485_direction_multidrop.sv
// testbench: rs485 direction control and multidrop receive filter
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
// ==========================================================================
// bench
module test_uart_rs485_direction_multidrop;
  typedef struct packed {
    logic [1:0] mode;
    logic       en;
    logic [7:0] d;
    logic       n;
    logic       push;
    logic       perr;
    logic       en_o;
  } row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, wr = 1'b0, flow = 1'b1, vld = 1'b0, nin = 1'b0, pe = 1'b0;
  logic [7:0]  adr = 8'h00, d = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, q;
  logic [5:0]  dly = 6'h03;
  logic [31:0] rdat;
  logic [7:0]  pd;
  logic        ack, done, rts_n, push, perr, irq;
  int          error_cnt = 0, check_count = 0;
  // mode 0 plain, 1 normal multidrop, 2 address match
  row_t rows[11] = '{
    '{2'h0, 1'b0, 8'h55, 1'b0, 1'b1, 1'b0, 1'b0}, '{2'h1, 1'b0, 8'h55, 1'b0, 1'b0, 1'b0, 1'b0},
    '{2'h1, 1'b0, 8'h33, 1'b1, 1'b1, 1'b1, 1'b0}, '{2'h1, 1'b1, 8'h55, 1'b0, 1'b1, 1'b0, 1'b1},
    '{2'h1, 1'b1, 8'h34, 1'b1, 1'b1, 1'b1, 1'b1}, '{2'h2, 1'b0, 8'h55, 1'b0, 1'b0, 1'b0, 1'b0},
    '{2'h2, 1'b0, 8'h33, 1'b1, 1'b0, 1'b0, 1'b0}, '{2'h2, 1'b0, 8'hA5, 1'b1, 1'b1, 1'b1, 1'b1},
    '{2'h2, 1'b1, 8'h55, 1'b0, 1'b1, 1'b0, 1'b1}, '{2'h2, 1'b1, 8'hA5, 1'b1, 1'b1, 1'b1, 1'b1},
    '{2'h2, 1'b1, 8'h33, 1'b1, 1'b0, 1'b0, 1'b0}};

  rs485_ctrl rs485_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tx_fifo_write_i(wr),
    .tx_done_i(done), .flow_rts_n_i(flow), .rx_char_valid_i(vld), .rx_char_data_i(d), .rx_char_ninth_i(nin),
    .rx_parity_err_i(pe), .rts_n_o(rts_n), .rx_push_o(push), .rx_push_data_o(pd), .rx_push_perr_o(perr),
    .irq_o(irq));
  rs485_line_model rs485_line_model_inst (.clk_i(clk_i), .rst_i(rst_i), .fifo_write_i(wr), .delay_i(dly),
    .done_o(done));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic conclude;
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    int i;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, 4'h1, 24'h00_0000, v};
    i = 0;
    // ack is looked at as sampled by the edge itself, read data taken at that same edge
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 40);
    if (ack !== 1'b1) begin
      error_cnt++;
      conclude();
    end
    q = rdat;
    {cyc, stb} <= 2'h0;
  endtask

  // lines released after the char show the inverse, never the old value
  task automatic rxc(input logic [7:0] c, input logic n);
    @(posedge clk_i);
    {vld, d, nin} <= {1'b1, c, n};
    @(posedge clk_i);
    {vld, d, nin} <= {1'b0, ~c, ~n};
    #1;
  endtask

  task automatic frame(input logic idle);
    int i;
    @(posedge clk_i);
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("rts busy", ~idle, rts_n)
    i = 0;
    while (rts_n !== idle && i < 60) begin
      @(posedge clk_i);
      #1;
      i++;
    end
    `CHK("rts done", idle, rts_n)
    if (i >= 60) conclude();
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b1, rs485_pkg::OFF_MODEM_CONTROL, 8'h02);
    #1;
    `CHK("rts manual", 1'b0, rts_n)
    bus(1'b1, rs485_pkg::OFF_ENHANCED, 8'h40);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      flow <= k[0];
      @(posedge clk_i);
      #1;
      `CHK("rts flow", k[0], rts_n)
    end
    bus(1'b1, rs485_pkg::OFF_ENHANCED, 8'h00);
    bus(1'b1, rs485_pkg::OFF_EXTRA_FEATURES, 8'h10);
    frame(1'b1);
    dly <= 6'h14;
    bus(1'b1, rs485_pkg::OFF_EXTRA_FEATURES, 8'h30);
    frame(1'b0);
    bus(1'b1, rs485_pkg::OFF_LINE_FORMAT, 8'h38);
    bus(1'b1, rs485_pkg::OFF_INT_ENABLE, 8'h04);
    bus(1'b1, rs485_pkg::OFF_IRQ_MASK, 8'h03);
    bus(1'b1, rs485_pkg::OFF_PAUSE_CHAR2, 8'hA5);
    foreach (rows[r]) begin
      bus(1'b1, rs485_pkg::OFF_EXTRA_FEATURES, {7'h00, rows[r].mode != 2'h0});
      bus(1'b1, rs485_pkg::OFF_ENHANCED, {2'h0, rows[r].mode[1], 5'h00});
      bus(1'b1, rs485_pkg::OFF_RX_ENABLE, {7'h00, rows[r].en});
      rxc(rows[r].d, rows[r].n);
      `CHK("push", rows[r].push, push)
      `CHK("perr", rows[r].perr, perr & push)
      `CHK("irq", rows[r].push & rows[r].n, irq)
      bus(1'b0, rs485_pkg::OFF_IRQ_STATUS, 8'h00);
      `CHK("status", {6'h00, {2{rows[r].push & rows[r].n}}}, q[7:0])
      bus(1'b0, rs485_pkg::OFF_RX_ENABLE, 8'h00);
      `CHK("rx en", rows[r].en_o, q[0])
    end
    bus(1'b1, rs485_pkg::OFF_ENHANCED, 8'h00);
    bus(1'b1, rs485_pkg::OFF_IRQ_MASK, 8'h00);
    rxc(8'h33, 1'b1);
    `CHK("irq masked", 1'b0, irq)
    bus(1'b0, rs485_pkg::OFF_IRQ_STATUS, 8'h00);
    `CHK("status masked", 8'h03, q[7:0])
    bus(1'b0, rs485_pkg::OFF_LINE_STATE, 8'h00);
    `CHK("line perr", 1'b1, q[2])
    bus(1'b1, rs485_pkg::OFF_INT_ENABLE, 8'h00);
    rxc(8'h33, 1'b1);
    bus(1'b0, rs485_pkg::OFF_IRQ_STATUS, 8'h00);
    `CHK("status no ie", 8'h01, q[7:0])
    bus(1'b1, rs485_pkg::OFF_EXTRA_FEATURES, 8'h00);
    pe <= 1'b1;
    rxc(8'h5A, 1'b1);
    `CHK("perr plain", 1'b1, perr & push)
    bus(1'b1, 8'h2C, 8'h5A);
    bus(1'b0, 8'h2C, 8'h00);
    `CHK("unmapped", 32'h0000_0000, q)
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK("rts reset", 1'b1, rts_n)
    for (int a = 0; a < 11; a++) begin
      bus(1'b0, 8'(a * 4), 8'h00);
      `CHK("reset reg", (a == 5) ? 32'h0000_0001 << rs485_pkg::LSR_TX_IDLE : 32'h0000_0000, q)
    end
    conclude();
  end
endmodule // test_uart_rs485_direction_multidrop
